// File: ssc_pkg.sv
// Purpose: Constants and types for the serial slave capture block.
// Assumes: Register indices are word indices; byte address is index * 4.
// Notes: Frame is one command byte then a 16-bit address, MSB first.
// Notes on behaviour
// - The captured 16-bit master address reads as a high byte and a low byte at consecutive locations.
// - The captured command byte from the master reads in a read-only register.
// - The serial slave port works on the four shared pins only while the enable bit is set, and that bit resets to zero.
// - Hardware sets the interrupt flag on each complete 24-bit frame and it stays set until software clears it.
package ssc_pkg;
  localparam int          PADDR_W     = 18;
  localparam logic [15:0] IDX_ENABLE  = 16'h2070;
  localparam logic [15:0] IDX_CMD     = 16'h2071;
  localparam logic [15:0] IDX_ADDR_HI = 16'h2072;
  localparam logic [15:0] IDX_ADDR_LO = 16'h2073;
  localparam logic [15:0] IDX_FLAG    = 16'h20b1;
  localparam logic [15:0] IDX_MASK    = 16'h20b2;
  localparam int          ENABLE_BIT  = 7;
  localparam int          FLAG_BIT    = 4;
  localparam logic        ENABLE_RST  = 1'b0;
  localparam logic        FLAG_RST    = 1'b0;
  localparam logic        MASK_RST    = 1'b0;
  localparam logic [7:0]  CAPTURE_RST = 8'h00;
  localparam logic [4:0]  FRAME_BITS  = 5'h18;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE  = 2'b11
  } ssc_state_t;
endpackage : ssc_pkg

// File: ssc_top.sv
// Purpose: Serial slave port capturing command and address, APB registers.
// Assumes: Link clock is slow against core_clk and sampled by it.
// Notes: Mode 0 framing, bits taken on rising link clock edges.
`timescale 1ns/10ps
`default_nettype none
module ssc_top
  import ssc_pkg::*;
(
  // Clock and reset.
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  // APB slave.
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Shared display pins carrying the serial port.
  input  wire logic               shared_display_pin_first,
  input  wire logic               ser_mosi_in,
  input  wire logic               ser_sel_n_in,
  input  wire logic               shared_display_pin_last_in,
  output logic                    shared_display_pin_last_out,
  output logic                    shared_display_pin_last_oe,
  // Interrupt.
  output logic                    irq
);

  logic [1:0]  sclk_sync_reg;
  logic [1:0]  mosi_sync_reg;
  logic [1:0]  sel_sync_reg;
  logic        sclk_prev_reg;
  logic        sel_prev_reg;
  logic        enable_reg;
  logic        flag_reg;
  logic        mask_reg;
  logic [7:0]  cmd_reg;
  logic [15:0] addr_reg;
  logic [23:0] shift_reg;
  logic [4:0]  bit_cnt_reg;
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        irq_reg;
  logic        miso_oe_reg;
  ssc_state_t  state_reg;
  ssc_state_t  state_next;

  logic        sclk_rise;
  logic        sel_rise;
  logic        sel_low;
  logic        apb_acc;
  logic        apb_wr;
  logic        hit;
  logic [15:0] idx;
  logic [31:0] rd_mux;

  // The first sync stage feeds only the second; edges use stage two.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sclk_sync_reg <= 2'h0;
      mosi_sync_reg <= 2'h0;
      sel_sync_reg  <= 2'h3;
      sclk_prev_reg <= 1'b0;
      sel_prev_reg  <= 1'b1;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], shared_display_pin_first};
      mosi_sync_reg <= {mosi_sync_reg[0], ser_mosi_in};
      sel_sync_reg  <= {sel_sync_reg[0], ser_sel_n_in};
      sclk_prev_reg <= sclk_sync_reg[1];
      sel_prev_reg  <= sel_sync_reg[1];
    end
  end

  assign sclk_rise = sclk_sync_reg[1] & ~sclk_prev_reg;
  assign sel_rise  = sel_sync_reg[1] & ~sel_prev_reg;
  assign sel_low   = ~sel_sync_reg[1];

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (enable_reg && sel_low) begin
          state_next = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (!enable_reg) begin
          state_next = ST_IDLE;
        end else if (sel_rise) begin
          state_next = (bit_cnt_reg == FRAME_BITS) ? ST_DONE : ST_IDLE;
        end
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Bits past the frame length are ignored; short frames are dropped.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      shift_reg   <= 24'h000000;
      bit_cnt_reg <= 5'h00;
    end else if (state_reg != ST_SHIFT) begin
      bit_cnt_reg <= 5'h00;
    end else if (sclk_rise && bit_cnt_reg != FRAME_BITS) begin
      shift_reg   <= {shift_reg[22:0], mosi_sync_reg[1]};
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cmd_reg  <= CAPTURE_RST;
      addr_reg <= {CAPTURE_RST, CAPTURE_RST};
    end else if (state_reg == ST_DONE) begin
      cmd_reg  <= shift_reg[23:16];
      addr_reg <= shift_reg[15:0];
    end
  end

  // The slave drives its output pin only while selected and enabled.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      miso_oe_reg <= 1'b0;
    end else begin
      miso_oe_reg <= (state_reg == ST_SHIFT) && sel_low;
    end
  end

  // APB: one wait state so that read data comes from a flop.
  assign idx     = paddr[PADDR_W-1:2];
  assign apb_acc = psel & penable & pready_reg;
  assign apb_wr  = apb_acc & pwrite & hit;

  always_comb begin
    hit    = (paddr[1:0] == 2'h0);
    rd_mux = 32'h00000000;
    case (idx)
      IDX_ENABLE:  rd_mux[ENABLE_BIT] = enable_reg;
      IDX_CMD:     rd_mux[7:0]        = cmd_reg;
      IDX_ADDR_HI: rd_mux[7:0]        = addr_reg[15:8];
      IDX_ADDR_LO: rd_mux[7:0]        = addr_reg[7:0];
      IDX_FLAG:    rd_mux[FLAG_BIT]   = flag_reg;
      IDX_MASK:    rd_mux[FLAG_BIT]   = mask_reg;
      default:     hit                = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= psel & penable & ~pready_reg;
      prdata_reg  <= (psel & ~pwrite) ? rd_mux : 32'h00000000;
      pslverr_reg <= psel & penable & ~pready_reg & ~hit;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      enable_reg <= ENABLE_RST;
      mask_reg   <= MASK_RST;
    end else if (apb_wr && idx == IDX_ENABLE) begin
      enable_reg <= pwdata[ENABLE_BIT];
    end else if (apb_wr && idx == IDX_MASK) begin
      mask_reg <= pwdata[FLAG_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flag_reg <= FLAG_RST;
    end else if (state_reg == ST_DONE) begin
      flag_reg <= 1'b1;
    end else if (apb_wr && idx == IDX_FLAG && !pwdata[FLAG_BIT]) begin
      flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= flag_reg & mask_reg;
    end
  end

  assign prdata                      = prdata_reg;
  assign pready                      = pready_reg;
  assign pslverr                     = pslverr_reg;
  assign irq                         = irq_reg;
  assign shared_display_pin_last_out = 1'b0;
  assign shared_display_pin_last_oe  = miso_oe_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  port_gate_a: assert property (
    !enable_reg |=> state_reg != ST_SHIFT)
    else $error("Port left idle while disabled.");
  cmd_capture_a: assert property (
    state_reg == ST_DONE |=> cmd_reg == $past(shift_reg[23:16]))
    else $error("Command byte not captured.");
  addr_capture_a: assert property (
    state_reg == ST_DONE |=> addr_reg == $past(shift_reg[15:0]))
    else $error("Address not captured.");
  capture_hold_a: assert property (
    state_reg != ST_DONE |=> $stable(cmd_reg) && $stable(addr_reg))
    else $error("Captured values changed outside a frame end.");
  flag_set_a: assert property (
    state_reg == ST_DONE |=> flag_reg)
    else $error("Flag not set after a frame.");
  flag_hold_a: assert property (
    flag_reg && !(apb_wr && idx == IDX_FLAG && !pwdata[FLAG_BIT])
      |=> flag_reg)
    else $error("Flag dropped without a clearing write.");
  flag_clear_a: assert property (
    flag_reg && apb_wr && idx == IDX_FLAG && pwdata[FLAG_BIT]
      && state_reg != ST_DONE |=> flag_reg)
    else $error("Writing one cleared the flag.");
  apb_wait_a: assert property (
    psel && penable && !pready_reg |=> pready_reg ##1 !pready_reg)
    else $error("APB answer not after one wait state.");
  irq_level_a: assert property (
    flag_reg && mask_reg |-> ##1 irq_reg)
    else $error("Interrupt not raised.");

  frame_done_c: cover property (state_reg == ST_DONE);
  short_frame_c: cover property (
    state_reg == ST_SHIFT && sel_rise && bit_cnt_reg != FRAME_BITS);
  irq_clear_c: cover property (irq_reg ##[1:20] !irq_reg);
  abort_c: cover property (state_reg == ST_SHIFT && !enable_reg);

endmodule : ssc_top
`default_nettype wire

// File: ssc_master_model.sv
// Purpose: Behavioural master that sends serial frames to the port.
// Assumes: Clock idles low, data changes while the clock is low.
// Notes: Data line is inverted after a frame so stale bits never match.
`timescale 1ns/10ps
`default_nettype none
module ssc_master_model (
  // Serial lines.
  output logic sclk,
  output logic mosi,
  output logic sel_n
);
  initial begin
    sclk  = 1'b0;
    mosi  = 1'b0;
    sel_n = 1'b1;
  end
  task automatic send(input logic [23:0] f, input int n);
    sel_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi = f[23-i];
      #100;
      sclk = 1'b1;
      #100;
      sclk = 1'b0;
    end
    #100;
    mosi  = ~mosi;
    sel_n = 1'b1;
    #200;
  endtask : send
endmodule : ssc_master_model
`default_nettype wire

// File: ssc_top_test.sv
// Purpose: Self-checking bench for the serial capture block.
// Assumes: Byte address is the word index times four.
// Notes: Frames take 200 ns per bit, so waits are generous.
`timescale 1ns/10ps
`default_nettype none
module ssc_top_test
  import ssc_pkg::*;
;
  logic               core_clk, sys_rst, psel, penable, pwrite;
  logic [PADDR_W-1:0] paddr;
  logic [31:0]        pwdata, prdata, d;
  logic               pready, pslverr, irq, sclk, mosi, sel_n, e;
  logic               oe;
  int                 failures, tests_run;
  ssc_master_model m (.sclk(sclk), .mosi(mosi), .sel_n(sel_n));
  ssc_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shared_display_pin_first(sclk), .ser_mosi_in(mosi),
    .ser_sel_n_in(sel_n), .shared_display_pin_last_in(1'b0),
    .shared_display_pin_last_out(), .shared_display_pin_last_oe(oe),
    .irq(irq));
  task automatic finish_test;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] i,
                     input logic [31:0] wd);
    int n;
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {i, 2'b00};
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      failures++;
      finish_test();
    end
  endtask : apb
  task automatic wr(input logic [15:0] i, input logic [31:0] wd);
    apb(1'b1, i, wd);
  endtask : wr
  task automatic rd(input logic [15:0] i, input logic [31:0] x);
    apb(1'b0, i, 32'h0);
    chk(d, x);
  endtask : rd
  // The interrupt lags the flag by a cycle, so look two cycles on.
  task automatic irq_is(input logic x);
    repeat (2) @(negedge core_clk);
    chk({31'h0, irq}, {31'h0, x});
  endtask : irq_is
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    failures  = 0;
    tests_run = 0;
    sys_rst   = 1'b1;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = '0;
    pwdata    = 32'h0;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd(IDX_ENABLE, 32'h0);
    rd(IDX_CMD, 32'h0);
    $display("test reset done");
    fork
      m.send(24'h123456, 24);
      begin
        repeat (20) @(negedge core_clk);
        chk({31'h0, oe}, 32'h0);
      end
    join
    rd(IDX_CMD, 32'h0);
    rd(IDX_FLAG, 32'h0);
    $display("test disabled done");
    wr(IDX_FLAG, 32'h0);
    wr(IDX_ENABLE, 32'h80);
    rd(IDX_ENABLE, 32'h80);
    m.send(24'ha53cc3, 24);
    rd(IDX_CMD, 32'ha5);
    rd(IDX_ADDR_HI, 32'h3c);
    rd(IDX_ADDR_LO, 32'hc3);
    rd(IDX_FLAG, 32'h10);
    irq_is(1'b0);
    wr(IDX_FLAG, 32'h10);
    rd(IDX_FLAG, 32'h10);
    wr(IDX_FLAG, 32'h0);
    rd(IDX_FLAG, 32'h0);
    $display("test capture done");
    wr(IDX_MASK, 32'h10);
    fork
      m.send(24'h5a01fe, 24);
      begin
        repeat (20) @(negedge core_clk);
        chk({31'h0, oe}, 32'h1);
      end
    join
    irq_is(1'b1);
    rd(IDX_ADDR_LO, 32'hfe);
    rd(IDX_CMD, 32'h5a);
    wr(IDX_FLAG, 32'h0);
    irq_is(1'b0);
    $display("test irq done");
    m.send(24'h77ffff, 16);
    rd(IDX_CMD, 32'h5a);
    rd(IDX_FLAG, 32'h0);
    wr(IDX_CMD, 32'hff);
    rd(IDX_CMD, 32'h5a);
    // A frame cut by clearing the enable must leave no trace.
    fork
      m.send(24'h11aaaa, 24);
      begin
        repeat (40) @(posedge core_clk);
        wr(IDX_ENABLE, 32'h0);
        repeat (3) @(negedge core_clk);
        chk({31'h0, oe}, 32'h0);
      end
    join
    rd(IDX_ENABLE, 32'h0);
    rd(IDX_CMD, 32'h5a);
    rd(IDX_FLAG, 32'h0);
    $display("test abort done");
    apb(1'b0, 16'h2074, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(d, 32'h0);
    $display("test refuse done");
    finish_test();
  end
endmodule : ssc_top_test
`default_nettype wire
